// ==== design/omce_host.sv ====
// What this block does
// - After reset, send skip code CCh, then the memory or status command.
// - Paged read sends C3h, address low byte, then high byte.
// - Whole-field read sends F0h and address; no page CRCs appear.
// - Write sends 0Fh, address low and high, then reads command CRC.
// - Host sends eight data bytes, then reads CRC over those bytes.
// - On matching CRC send 5Ah, then hold programming voltage 2500 us.
// - Write start address is a multiple of eight within 0000 to 007F.
// - On CRC mismatch or bad read-back, reset and repeat from start, up to three tries in all.
// - Status read sends AAh and address, reads bytes to field end, then CRC.
// - Address and data bytes travel least significant bit first.
// - Reset holds the line low at least 480 us; device answers presence.
// - Each read or write slot starts with a host low strobe; data follows.
module omce_host
  import omce_pkg::*;
#(
  parameter int RST_US    = T_RST_US,
  parameter int RSTREC_US = T_RSTREC_US,
  parameter int PSAMP_US  = T_PSAMP_US,
  parameter int PROG_US   = T_PROG_US,
  parameter int SLOT_US   = T_SLOT_US,
  parameter int TRIES     = MAX_TRY,
  parameter int TICK_DIV  = TICK_CYC
)
(
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Command request and result.
  input  wire logic         cmd_valid_i,
  input  wire omce_cmd_type cmd_i,
  output logic              cmd_ready_o,
  output logic              done_o,
  output omce_stat_type     stat_o,
  // Write data stream.
  input  wire logic         wd_valid_i,
  input  wire logic [7:0]   wd_data_i,
  output logic              wd_ready_o,
  // Read data stream.
  output logic              rd_valid_o,
  output logic [7:0]        rd_data_o,
  input  wire logic         rd_ready_i,
  // Single-wire line.
  input  wire logic         dq_i,
  output logic              dq_o,
  output logic              dq_oe_o,
  output logic              pp_en_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_LOAD, S_RST, S_SKIP, S_CMD, S_ALO, S_AHI, S_CCRC,
    S_WDATA, S_WCRC, S_PCTL, S_PROG, S_RBACK, S_RDATA, S_DCRC, S_END
  } omce_state_type;

  omce_state_type st_q;
  omce_cmd_type   cmd_q;
  omce_slot_type  sl_op_q;
  omce_slot_type  op_d;
  logic [15:0]    addr_q;
  logic [7:0]     sh_q;
  logic [7:0]     crc_q;
  logic [7:0]     stg_q [WR_BYTES];
  logic [7:0]     rx_byte;
  logic [7:0]     nxt_tx;
  logic [7:0]     code;
  logic [7:0]     rb_bits;
  logic [7:0]     f_data;
  logic [2:0]     bit_q;
  logic [2:0]     idx_q;
  logic [3:0]     try_q;
  logic           wait_q;
  logic           sl_start_q;
  logic           rb_bad_q;
  logic           sl_done;
  logic           sl_smp;
  logic           f_valid;
  logic           f_take;
  logic           is_rx;
  logic           is_byte;
  logic           byte_done;
  logic           crc_ok;
  logic           crc_upd;
  logic           stall;
  logic           issue;
  logic           end_hit;
  logic           can_retry;
  logic           cmd_bad;
  logic           crc_bad;
  logic           rb_fail;
  logic           no_pres;
  logic           fail;

  // The line is open drain: the host only ever pulls it low.
  assign dq_o = 1'b0;

  assign is_rx     = st_q inside {S_CCRC, S_WCRC, S_RBACK, S_RDATA, S_DCRC};
  assign is_byte   = is_rx ||
                     st_q inside {S_SKIP, S_CMD, S_ALO, S_AHI, S_WDATA, S_PCTL};
  assign byte_done = sl_done && is_byte && bit_q == 3'h7;
  assign rx_byte   = {sl_smp, sh_q[7:1]};
  assign crc_ok    = rx_byte == crc_q;
  assign crc_upd   = sl_done &&
                     st_q inside {S_CMD, S_ALO, S_AHI, S_WDATA, S_RDATA};
  assign stall     = st_q == S_RDATA && rd_valid_o && !rd_ready_i;
  assign issue     = (is_byte || st_q inside {S_RST, S_PROG}) &&
                     !wait_q && !stall;
  assign op_d      = (st_q == S_RST)  ? SL_RST  :
                     (st_q == S_PROG) ? SL_PROG :
                     is_rx ? SL_READ : (sh_q[0] ? SL_WR1 : SL_WR0);
  assign code      = (cmd_q.kind == OP_PAGE)  ? CODE_PAGE  :
                     (cmd_q.kind == OP_FIELD) ? CODE_FIELD :
                     (cmd_q.kind == OP_WRITE) ? CODE_WRITE : CODE_STAT;
  assign nxt_tx    = (st_q == S_RST)  ? CODE_SKIP         :
                     (st_q == S_SKIP) ? code              :
                     (st_q == S_CMD)  ? cmd_q.addr[7:0]   :
                     (st_q == S_ALO)  ? cmd_q.addr[15:8]  :
                     (st_q == S_CCRC) ? stg_q[0]          :
                     (st_q == S_WCRC) ? CODE_PCTL : stg_q[3'(idx_q + 1'b1)];
  assign end_hit   = (cmd_q.kind == OP_PAGE && addr_q[4:0] == PAGE_LAST) ||
                     addr_q == (cmd_q.kind == OP_STAT ? STAT_LAST : MEM_LAST);
  assign can_retry = try_q < 4'(TRIES - 1);
  assign cmd_bad   = cmd_i.addr > (cmd_i.kind == OP_STAT ? STAT_LAST
                                                         : MEM_LAST) ||
                     (cmd_i.kind == OP_WRITE &&
                      (cmd_i.addr[2:0] & WR_ALIGN_MASK) != 3'h0);
  assign f_take    = st_q == S_LOAD && f_valid;
  assign rb_bits   = rx_byte & ~stg_q[idx_q];
  assign crc_bad   = byte_done && !crc_ok &&
                     st_q inside {S_CCRC, S_WCRC, S_DCRC};
  assign rb_fail   = byte_done && st_q == S_RBACK && idx_q == 3'h7 &&
                     (rb_bad_q || |rb_bits);
  assign no_pres   = sl_done && st_q == S_RST && sl_smp;
  assign fail      = crc_bad || rb_fail || no_pres;

  omce_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wd_valid_i),
    .in_data_i   (wd_data_i),
    .in_ready_o  (wd_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_take)
  );

  omce_slot #(
    .RST_US    (RST_US),
    .RSTREC_US (RSTREC_US),
    .PSAMP_US  (PSAMP_US),
    .PROG_US   (PROG_US),
    .SLOT_US   (SLOT_US),
    .TICK_DIV  (TICK_DIV)
  ) u_slot (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (sl_start_q),
    .op_i    (sl_op_q),
    .done_o  (sl_done),
    .smp_o   (sl_smp),
    .dq_i    (dq_i),
    .dq_oe_o (dq_oe_o),
    .pp_en_o (pp_en_o)
  );

  always_ff @(posedge clk_i)
  begin
    if (f_take)
      stg_q[idx_q] <= f_data;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sl_start_q <= 1'b0;
      sl_op_q    <= SL_WR1;
      wait_q     <= 1'b0;
      sh_q       <= '0;
      bit_q      <= '0;
    end
    else
    begin
      sl_start_q <= issue;
      sl_op_q    <= issue ? op_d : sl_op_q;
      wait_q     <= issue || (wait_q && !sl_done);
      if (byte_done || (sl_done && st_q == S_RST))
        sh_q <= nxt_tx;
      else if (sl_done)
        sh_q <= rx_byte;
      if (sl_done && is_byte)
        bit_q <= 3'(bit_q + 1'b1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q        <= S_IDLE;
      cmd_q       <= '0;
      addr_q      <= '0;
      idx_q       <= '0;
      try_q       <= '0;
      crc_q       <= CRC_INIT;
      rb_bad_q    <= 1'b0;
      stat_o      <= '0;
      done_o      <= 1'b0;
      cmd_ready_o <= 1'b1;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (rd_ready_i)
        rd_valid_o <= 1'b0;
      if (crc_upd)
        crc_q <= omce_crc_bit(crc_q, is_rx ? sl_smp : sh_q[0]);
      if (fail)
      begin
        stat_o.crc_err <= stat_o.crc_err | crc_bad;
        stat_o.rb_err  <= stat_o.rb_err | rb_fail;
        stat_o.no_pres <= stat_o.no_pres | no_pres;
        if (can_retry)
        begin
          try_q <= 4'(try_q + 1'b1);
          st_q  <= S_RST;
        end
        else
        begin
          stat_o.fail <= 1'b1;
          st_q        <= S_END;
        end
      end
      else
      begin
        case (st_q)
          S_IDLE:
            if (cmd_valid_i)
            begin
              cmd_q           <= cmd_i;
              idx_q           <= '0;
              try_q           <= '0;
              stat_o          <= '0;
              stat_o.bad_addr <= cmd_bad;
              stat_o.fail     <= cmd_bad;
              cmd_ready_o     <= 1'b0;
              st_q <= cmd_bad ? S_END :
                      (cmd_i.kind == OP_WRITE) ? S_LOAD : S_RST;
            end
          S_LOAD:
            if (f_valid)
            begin
              idx_q <= 3'(idx_q + 1'b1);
              st_q  <= (idx_q == 3'h7) ? S_RST : S_LOAD;
            end
          S_RST:
            st_q <= sl_done ? S_SKIP : S_RST;
          S_SKIP:
            if (byte_done)
            begin
              crc_q  <= CRC_INIT;
              addr_q <= cmd_q.addr;
              st_q   <= S_CMD;
            end
          S_CMD:
            st_q <= byte_done ? S_ALO : S_CMD;
          S_ALO:
            st_q <= byte_done ? S_AHI : S_ALO;
          S_AHI:
            st_q <= byte_done ? S_CCRC : S_AHI;
          S_CCRC:
            if (byte_done)
            begin
              crc_q <= CRC_INIT;
              idx_q <= '0;
              st_q  <= (cmd_q.kind == OP_WRITE) ? S_WDATA : S_RDATA;
            end
          S_WDATA:
            if (byte_done)
            begin
              idx_q <= 3'(idx_q + 1'b1);
              st_q  <= (idx_q == 3'h7) ? S_WCRC : S_WDATA;
            end
          S_WCRC:
            st_q <= byte_done ? S_PCTL : S_WCRC;
          S_PCTL:
            st_q <= byte_done ? S_PROG : S_PCTL;
          S_PROG:
            if (sl_done)
            begin
              idx_q    <= '0;
              rb_bad_q <= 1'b0;
              st_q     <= S_RBACK;
            end
          S_RBACK:
            if (byte_done)
            begin
              rb_bad_q <= rb_bad_q | (|rb_bits);
              idx_q    <= 3'(idx_q + 1'b1);
              st_q     <= (idx_q == 3'h7) ? S_END : S_RBACK;
            end
          S_RDATA:
            if (byte_done)
            begin
              rd_valid_o <= 1'b1;
              rd_data_o  <= rx_byte;
              addr_q     <= 16'(addr_q + 1'b1);
              st_q       <= end_hit ? S_DCRC : S_RDATA;
            end
          S_DCRC:
            if (byte_done)
            begin
              crc_q <= CRC_INIT;
              st_q  <= (cmd_q.kind == OP_PAGE && addr_q <= MEM_LAST)
                       ? S_RDATA : S_END;
            end
          S_END:
          begin
            done_o      <= 1'b1;
            cmd_ready_o <= 1'b1;
            st_q        <= S_IDLE;
          end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_skip_cmd;
    (st_q == S_SKIP && byte_done) |=> st_q == S_CMD ##0 sh_q == code;
  endproperty
  a_skip_cmd: assert property (p_skip_cmd)
    else $error("command does not follow skip");

  property p_addr_lo;
    (st_q == S_CMD && byte_done) |=> st_q == S_ALO && sh_q == addr_q[7:0];
  endproperty
  a_addr_lo: assert property (p_addr_lo)
    else $error("address low byte not next");

  property p_lsb_first;
    (sl_start_q && sl_op_q inside {SL_WR0, SL_WR1})
      |-> (sl_op_q == SL_WR1) == sh_q[0];
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("written bit is not the low bit");

  property p_eight_bytes;
    (st_q == S_WDATA ##1 st_q == S_WCRC) |-> $past(idx_q) == 3'h7;
  endproperty
  a_eight_bytes: assert property (p_eight_bytes)
    else $error("data byte count is not eight");

  property p_pctl_on_match;
    (st_q == S_WCRC && byte_done) |=> (st_q == S_PCTL) == $past(crc_ok);
  endproperty
  a_pctl_on_match: assert property (p_pctl_on_match)
    else $error("program control against CRC result");

  property p_retry;
    (crc_bad && can_retry) |=> st_q == S_RST ##1 sl_start_q;
  endproperty
  a_retry: assert property (p_retry)
    else $error("CRC mismatch did not restart");

  property p_stat_end;
    (st_q == S_RDATA && byte_done && cmd_q.kind == OP_STAT &&
     addr_q == STAT_LAST) |=> st_q == S_DCRC;
  endproperty
  a_stat_end: assert property (p_stat_end)
    else $error("status read did not end at field end");

  property p_bad_addr;
    (st_q == S_IDLE && cmd_valid_i && cmd_bad)
      |=> st_q == S_END ##1 (done_o && stat_o.bad_addr);
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("bad address was not refused");

  c_write_ok: cover property (st_q == S_END && cmd_q.kind == OP_WRITE &&
                              !stat_o.fail);
  c_page_end: cover property (st_q == S_DCRC && byte_done &&
                              addr_q > MEM_LAST);
  c_retry: cover property (fail && can_retry);

endmodule

// ==== design/omce_pkg.sv ====
package omce_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int US_PS         = 1000000;
  localparam int TICK_CYC      = US_PS / CLK_PERIOD_PS;

  // Line timing in microseconds, then the slot counter width in bits.
  localparam int T_RST_US    = 480;
  localparam int T_RSTREC_US = 480;
  localparam int T_PSAMP_US  = 70;
  localparam int T_PROG_US   = 2500;
  localparam int T_PSU_US    = 5;
  localparam int T_PREC_US   = 5;
  localparam int T_SLOT_US   = 60;
  localparam int T_STRB_US   = 1;
  localparam int T_RSAMP_US  = 13;
  localparam int T_REC_US    = 2;
  localparam int T_CNT_W     = 14;

  // Counts and sizes.
  localparam int MAX_TRY    = 3;
  localparam int WR_BYTES   = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W     = 8;

  // Command codes.
  localparam logic [7:0] CODE_SKIP  = 8'hCC;
  localparam logic [7:0] CODE_PAGE  = 8'hC3;
  localparam logic [7:0] CODE_FIELD = 8'hF0;
  localparam logic [7:0] CODE_WRITE = 8'h0F;
  localparam logic [7:0] CODE_STAT  = 8'hAA;
  localparam logic [7:0] CODE_PCTL  = 8'h5A;

  // CRC and address map.
  localparam logic [7:0]  CRC_POLY_REV  = 8'h8C;
  localparam logic [7:0]  CRC_INIT      = 8'h00;
  localparam logic [15:0] MEM_LAST      = 16'h007F;
  localparam logic [15:0] STAT_LAST     = 16'h0007;
  localparam logic [4:0]  PAGE_LAST     = 5'h1F;
  localparam logic [2:0]  WR_ALIGN_MASK = 3'h7;

  typedef enum logic [1:0] {OP_PAGE, OP_FIELD, OP_WRITE, OP_STAT}
    omce_kind_type;

  typedef enum logic [2:0] {SL_WR0, SL_WR1, SL_READ, SL_RST, SL_PROG}
    omce_slot_type;

  typedef struct packed {
    omce_kind_type kind;
    logic [15:0]   addr;
  } omce_cmd_type;

  typedef struct packed {
    logic fail;
    logic no_pres;
    logic crc_err;
    logic rb_err;
    logic bad_addr;
  } omce_stat_type;

  // One step of the reflected CRC, fed least significant bit first.
  function automatic logic [7:0] omce_crc_bit(input logic [7:0] crc,
                                              input logic       b);
    logic [7:0] s;
    s = {1'b0, crc[7:1]};
    return (crc[0] ^ b) ? (s ^ CRC_POLY_REV) : s;
  endfunction

endpackage

// ==== design/omce_fifo.sv ====
module omce_fifo
  import omce_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side.
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side.
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_ready_i && out_valid_o;
  assign cnt_d      = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem_q[rp_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wp_q] <= in_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_q        <= '0;
      rp_q        <= '0;
      cnt_q       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      wp_q        <= push ? AW'(wp_q + 1'b1) : wp_q;
      rp_q        <= pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_q       <= cnt_d;
      in_ready_o  <= cnt_d != (AW+1)'(DEPTH);
      out_valid_o <= cnt_d != '0;
    end
  end

endmodule

// ==== design/omce_slot.sv ====
module omce_slot
  import omce_pkg::*;
#(
  parameter int RST_US    = T_RST_US,
  parameter int RSTREC_US = T_RSTREC_US,
  parameter int PSAMP_US  = T_PSAMP_US,
  parameter int PROG_US   = T_PROG_US,
  parameter int SLOT_US   = T_SLOT_US,
  parameter int TICK_DIV  = TICK_CYC
)
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Slot request.
  input  wire logic          start_i,
  input  wire omce_slot_type op_i,
  output logic               done_o,
  output logic               smp_o,
  // Line drive.
  input  wire logic          dq_i,
  output logic               dq_oe_o,
  output logic               pp_en_o
);
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam int CW    = T_CNT_W;

  logic [DIV_W-1:0] div_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    low_us;
  logic [CW-1:0]    smp_us;
  logic [CW-1:0]    end_us;
  logic             busy_q;
  omce_slot_type    op_q;
  logic             tick;
  logic             last;
  logic             in_pp;

  // The microsecond tick is the only time base of a slot.
  assign tick   = busy_q && (div_q == DIV_W'(TICK_DIV - 1));
  assign low_us = (op_q == SL_WR0)  ? CW'(SLOT_US) :
                  (op_q == SL_RST)  ? CW'(RST_US)  :
                  (op_q == SL_PROG) ? '0 : CW'(T_STRB_US);
  assign smp_us = (op_q == SL_RST) ? CW'(RST_US + PSAMP_US)
                                   : CW'(T_RSAMP_US);
  assign end_us = (op_q == SL_RST)  ? CW'(RST_US + RSTREC_US) :
                  (op_q == SL_PROG) ? CW'(T_PSU_US + PROG_US + T_PREC_US)
                                    : CW'(SLOT_US + T_REC_US);
  assign last   = tick && (cnt_q == CW'(end_us - 1'b1));
  assign in_pp  = cnt_q >= CW'(T_PSU_US) && cnt_q < CW'(T_PSU_US + PROG_US);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_q  <= 1'b0;
      op_q    <= SL_WR1;
      div_q   <= '0;
      cnt_q   <= '0;
      done_o  <= 1'b0;
      smp_o   <= 1'b1;
      dq_oe_o <= 1'b0;
      pp_en_o <= 1'b0;
    end
    else
    begin
      done_o <= last;
      dq_oe_o <= busy_q && !last && cnt_q < low_us;
      pp_en_o <= busy_q && !last && op_q == SL_PROG && in_pp;
      if (tick && cnt_q == smp_us)
        smp_o <= dq_i;
      if (!busy_q && start_i)
      begin
        busy_q <= 1'b1;
        op_q   <= op_i;
        cnt_q  <= '0;
        div_q  <= '0;
      end
      else if (busy_q)
      begin
        div_q  <= tick ? '0 : DIV_W'(div_q + 1'b1);
        cnt_q  <= tick ? CW'(cnt_q + 1'b1) : cnt_q;
        busy_q <= !last;
      end
    end
  end

  int low_run_q;
  int pp_run_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_run_q <= 0;
      pp_run_q  <= 0;
    end
    else
    begin
      low_run_q <= dq_oe_o ? low_run_q + 1 : 0;
      pp_run_q  <= pp_en_o ? pp_run_q + 1 : 0;
    end
  end

  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_rst_low;
    ($fell(dq_oe_o) && op_q == SL_RST) |-> low_run_q >= RST_US * TICK_DIV;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("reset low too short");

  property p_prog_len;
    $fell(pp_en_o) |-> pp_run_q >= PROG_US * TICK_DIV && !dq_oe_o;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming pulse too short");

endmodule

// ==== test/omce_dev_model.sv ====
module omce_dev_model
  import omce_pkg::*;
#(parameter int PROG_NS = 10000)
(
  // Line side.
  input  wire logic line_i,
  input  wire logic pp_en_i,
  output logic      dev_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic [7:0] crc;
  logic       crc_flip;
  realtime    t_fall;
  event       rst_ev;

  initial
  begin
    dev_oe_o = 1'b0;
    crc_flip = 1'b0;
    for (int i = 0; i < 128; i++)
      mem[i] = (i < 8'h70) ? 8'(i) * 8'h1D + 8'h03 : 8'hFF;
  end

  task automatic crc_step(input logic b);
    crc = (crc[0] ^ b) ? {1'b0, crc[7:1]} ^ CRC_POLY_REV : {1'b0, crc[7:1]};
  endtask

  task automatic rx_byte(output logic [7:0] v);
    realtime t;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge line_i);
      t = $realtime;
      @(posedge line_i);
      v[i] = ($realtime - t) < 100.0;
      crc_step(v[i]);
    end
  endtask

  task automatic tx_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge line_i);
      crc_step(v[i]);
      dev_oe_o = ~v[i];
      #120 dev_oe_o = 1'b0;
    end
  endtask

  task automatic session();
    logic [7:0] c;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] wbuf [8];
    realtime    t;
    int         a;
    #80 dev_oe_o = 1'b1;
    #400 dev_oe_o = 1'b0;
    crc = 8'h00;
    rx_byte(c);
    if (c != CODE_SKIP)
      return;
    crc = 8'h00;
    rx_byte(c);
    rx_byte(lo);
    rx_byte(hi);
    a = int'({hi, lo});
    // command CRC, spoiled once on request
    tx_byte(crc ^ {8{crc_flip}});
    crc_flip = 1'b0;
    crc = 8'h00;
    if (c == CODE_STAT)
    begin
      for (; a < 8; a++)
        tx_byte((a == 7) ? 8'h00 : 8'hFF);
      tx_byte(crc);
      return;
    end
    if (c != CODE_PAGE && c != CODE_FIELD && c != CODE_WRITE)
      return;
    if (c != CODE_WRITE)
    begin
      for (; a < 128; a++)
      begin
        tx_byte(mem[a]);
        if (c == CODE_PAGE && a[4:0] == 5'h1F)
        begin
          tx_byte(crc);
          crc = 8'h00;
        end
      end
      if (c == CODE_FIELD)
        tx_byte(crc);
      return;
    end
    for (int i = 0; i < 8; i++)
      rx_byte(wbuf[i]);
    tx_byte(crc);
    rx_byte(c);
    if (c != CODE_PCTL)
      return;
    @(posedge pp_en_i);
    t = $realtime;
    @(negedge pp_en_i);
    for (int i = 0; i < 8; i++)
      if ($realtime - t >= PROG_NS)
        mem[a + i] = mem[a + i] & wbuf[i];
    for (int i = 0; i < 8; i++)
      tx_byte(mem[a + i]);
  endtask

  always @(negedge line_i) t_fall = $realtime;
  always @(posedge line_i) if ($realtime - t_fall > 1000.0) -> rst_ev;

  initial
    forever
    begin
      @(rst_ev);
      disable fork;
      dev_oe_o = 1'b0;
      fork
        session();
      join_none
    end
endmodule

// ==== test/otp_memory_command_engine_tb.sv ====
module otp_memory_command_engine_tb
  import omce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_i;
  logic          rst_i;
  logic          cmd_valid_i;
  omce_cmd_type  cmd_i;
  logic          cmd_ready_o;
  logic          done_o;
  omce_stat_type stat_o;
  logic          wd_valid_i;
  logic [7:0]    wd_data_i;
  logic          wd_ready_o;
  logic          rd_valid_o;
  logic [7:0]    rd_data_o;
  logic          dq_oe_o;
  logic          pp_en_o;
  logic          dev_oe;
  logic          rd_ready;
  int            stall_n;
  wire           line;
  int            n_mismatch;
  int            checks;
  int            cyc;
  logic [7:0]    q [$];

  // Open-drain line with pull-up.
  assign line = ~(dq_oe_o | dev_oe);
  always #2 clk_i = ~clk_i;

  // One tick per cycle keeps the run short; the line model is scaled to it.
  omce_host #(.TICK_DIV(1)) omce_host_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .stat_o(stat_o), .wd_valid_i(wd_valid_i),
    .wd_data_i(wd_data_i), .wd_ready_o(wd_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_ready_i(rd_ready), .dq_i(line), .dq_o(),
    .dq_oe_o(dq_oe_o), .pp_en_o(pp_en_o));
  omce_dev_model omce_dev_model_inst (.line_i(line),
    .pp_en_i(pp_en_o), .dev_oe_o(dev_oe));

  function automatic logic [7:0] wdat(int i);
    return 8'h96 ^ (8'(i) * 8'h11);
  endfunction

  function automatic logic [7:0] ref_byte(int a);
    logic [7:0] v;
    v = (a < 8'h70) ? 8'(a) * 8'h1D + 8'h03 : 8'hFF;
    return (a >= 8'h68 && a < 8'h70) ? v & wdat(a - 8'h68) : v;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input omce_kind_type k, input logic [15:0] a);
    q.delete();
    cmd_i = {k, a};
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    forever
    begin
      if (stall_n > 0 && rd_valid_o === 1'b1)
        stall_n--;
      rd_ready = stall_n == 0;
      if (rd_valid_o === 1'b1 && rd_ready === 1'b1)
        q.push_back(rd_data_o);
      if (done_o === 1'b1)
        break;
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic t_refuse();
    run(OP_WRITE, 16'h0079);
    chk({3'h0, stat_o}, 8'h11);
    run(OP_STAT, 16'h0008);
    chk({3'h0, stat_o}, 8'h11);
  endtask

  task automatic t_status();
    omce_dev_model_inst.crc_flip = 1'b1;
    stall_n = 100;
    run(OP_STAT, 16'h0006);
    chk({3'h0, stat_o}, 8'h04);
    chk(8'(q.size()), 8'h02);
    chk(q[0], 8'hFF);
    chk(q[1], 8'h00);
  endtask

  task automatic t_field();
    run(OP_FIELD, 16'h007C);
    chk({3'h0, stat_o}, 8'h00);
    chk(8'(q.size()), 8'h04);
    for (int i = 0; i < 4; i++)
      chk(q[i], 8'hFF);
  endtask

  task automatic t_write();
    wd_valid_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      wd_data_i = wdat(i);
      @(posedge clk_i);
      #1;
    end
    wd_valid_i = 1'b0;
    run(OP_WRITE, 16'h0068);
    chk({3'h0, stat_o}, 8'h00);
  endtask

  task automatic t_page();
    run(OP_PAGE, 16'h005C);
    chk({3'h0, stat_o}, 8'h00);
    chk(8'(q.size()), 8'h24);
    for (int i = 0; i < 36; i++)
      chk(q[i], ref_byte(8'h5C + i));
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    wd_valid_i = 1'b0;
    wd_data_i = 8'h00;
    rd_ready = 1'b1;
    stall_n = 0;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_refuse();
    t_status();
    t_field();
    t_write();
    t_page();
    finish_test();
  end
endmodule
